// ==== verilog/serdes_rx_cfg.sv ====
// serdes mode, receive configuration and receive status block
//
// The address map and the Wishbone slave port are this design's own decisions.
`include "serdes_rx_defines.svh"
`default_nettype none
module serdes_rx_cfg #(
  parameter logic REV_VALUE = 1'b0 // arbitrary revision value
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic LINK_CLK,
  input wire logic RX_DATA,
  input wire logic RX_FRAME,
  input wire logic RX_CARRIER,
  input wire logic LINE_POL_REV,
  input wire logic TX_BUSY,
  output logic [1:0] SERIAL_CLK_SEL,
  output serdes_rx_pkg::proto_t PROTOCOL,
  output logic USB_LOW_SPEED,
  output logic USB_HIGH_SPEED,
  output logic CLK_POL_NEG,
  output logic RX_ON_FALL,
  output logic TX_ON_FALL,
  output logic MASTER_MODE,
  output logic SYNC_DETECT_EN,
  output logic MSB_FIRST,
  output logic TX_HOLD,
  output logic [15:0] RX_WORD,
  output logic [4:0] RX_WORD_BITS,
  output logic RX_WORD_VALID
);
  import serdes_rx_pkg::*;
  // software visible state
  logic [6:0] mode_q; // mode register minus the revision bit
  logic [7:0] rcfg_q; // receive config register
  logic [1:0] ract_q; // bit order and busy enable
  bitcnt_t acnt_q; // actual bits of last word
  logic ack_q;
  logic [31:0] dat_q;
  rx_state_e st_q; // link side receiver state
  logic bit_q, frame_q, tog_l_q; // sampled bit, frame, word toggle
  logic [15:0] sh_q, word_l_q; // shifter and word held for the core
  bitcnt_t cnt_q, wbits_l_q; // bits so far, bits of the held word
  // pin and word toggle synchronisers toward the core clock
  logic crs_s1_q, crs_s2_q;
  logic pol_s1_q, pol_s2_q;
  logic busy_s1_q, busy_s2_q;
  logic tog_s1_q, tog_s2_q, tog_s3_q;
  // decoded fields
  proto_t proto;
  clksrc_t clksrc;
  logic [1:0] sub;
  logic proto_valid;
  logic unit_on;
  logic is_gpsi, is_spi, is_usb, is_10bt;
  logic wb_req, wb_wr;
  logic [7:0] rd_mux;
  assign proto = mode_q[`MODE_PROTO];
  assign clksrc = mode_q[`MODE_CLK];
  assign sub = mode_q[`MODE_SUB];
  assign is_gpsi = (proto == `PRO_GPSI);
  assign is_spi = (proto == `PRO_SPI);
  assign is_usb = (proto == `PRO_USB);
  assign is_10bt = (proto == `PRO_10BT);
  // reserved codes behave as disabled
  assign proto_valid = is_10bt | is_usb | is_spi | is_gpsi |
                       (proto == `PRO_UART);
  assign unit_on = proto_valid & (clksrc != `CLK_STOP);
  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  // a write lands on the edge at which the master sees ack high
  assign wb_wr = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I & WB_SEL_I[0];
  // classic wishbone: ack one cycle after the strobe, dropped after
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end
  // read mux; unmapped offsets answer zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (WB_ADR_I)
      `OFS_MODE: rd_mux = {REV_VALUE, mode_q};
      `OFS_RCFG: begin
        rd_mux = rcfg_q;
        // polarity is reported, not stored, in 10bt mode
        if (is_10bt) begin
          rd_mux[`RCFG_MSTPOL] = pol_s2_q;
        end
      end
      `OFS_RACT: rd_mux = {ract_q, crs_s2_q, acnt_q};
      default: rd_mux = 8'h00;
    endcase
  end
  // read data registered with the ack
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dat_q <= 32'h0000_0000;
    end else if (wb_req && !WB_WE_I) begin
      dat_q <= {24'h00_0000, rd_mux};
    end
  end
  // register writes; revision, carrier and count bits ignore writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode_q <= `RST_MODE;
      rcfg_q <= `RST_RCFG;
      ract_q <= `RST_RACT;
    end else if (wb_wr) begin
      // after a switch to the oscillator the core must pause
      if (WB_ADR_I == `OFS_MODE) begin
        mode_q <= WB_DAT_I[6:0];
      end
      if (WB_ADR_I == `OFS_RCFG) begin
        rcfg_q <= WB_DAT_I[7:0];
      end
      if (WB_ADR_I == `OFS_RACT) begin
        ract_q <= WB_DAT_I[7:6];
      end
    end
  end
  // two flop synchronisers for pins and the word toggle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      crs_s1_q <= 1'b0;
      crs_s2_q <= 1'b0;
      pol_s1_q <= 1'b0;
      pol_s2_q <= 1'b0;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else begin
      crs_s1_q <= RX_CARRIER;
      crs_s2_q <= crs_s1_q;
      pol_s1_q <= LINE_POL_REV;
      pol_s2_q <= pol_s1_q;
      busy_s1_q <= TX_BUSY;
      busy_s2_q <= busy_s1_q;
      tog_s1_q <= tog_l_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end
  // decode of submode into edge and polarity controls
  logic pol_neg_d, rx_fall_d, tx_fall_d;
  always_comb begin
    pol_neg_d = 1'b0;
    rx_fall_d = 1'b0;
    tx_fall_d = 1'b1;
    if (is_spi) begin
      unique case (sub)
        `SUB_0: begin
          rx_fall_d = 1'b0;
          tx_fall_d = 1'b1;
        end
        `SUB_1: begin
          rx_fall_d = 1'b1;
          tx_fall_d = 1'b0;
        end
        `SUB_2: begin
          pol_neg_d = 1'b1;
          rx_fall_d = 1'b1;
          tx_fall_d = 1'b0;
        end
        `SUB_3: begin
          pol_neg_d = 1'b1;
          rx_fall_d = 1'b0;
          tx_fall_d = 1'b1;
        end
      endcase
    end else if (is_gpsi) begin
      unique case (sub)
        `SUB_0: begin
          rx_fall_d = 1'b0;
          tx_fall_d = 1'b1;
        end
        `SUB_1: begin
          rx_fall_d = 1'b1;
          tx_fall_d = 1'b1;
        end
        `SUB_2: begin
          rx_fall_d = 1'b0;
          tx_fall_d = 1'b0;
        end
        `SUB_3: begin
          rx_fall_d = 1'b1;
          tx_fall_d = 1'b0;
        end
      endcase
    end
  end
  // registered control outputs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SERIAL_CLK_SEL <= `CLK_STOP;
      PROTOCOL <= `PRO_OFF;
      USB_LOW_SPEED <= 1'b0;
      USB_HIGH_SPEED <= 1'b0;
      CLK_POL_NEG <= 1'b0;
      RX_ON_FALL <= 1'b0;
      TX_ON_FALL <= 1'b1;
      MASTER_MODE <= 1'b0;
      SYNC_DETECT_EN <= 1'b0;
      MSB_FIRST <= 1'b0;
      TX_HOLD <= 1'b0;
    end else begin
      // stopped source means no serial clock
      SERIAL_CLK_SEL <= proto_valid ? clksrc : `CLK_STOP;
      PROTOCOL <= proto_valid ? proto : `PRO_OFF;
      USB_LOW_SPEED <= is_usb & (sub == `SUB_1);
      USB_HIGH_SPEED <= is_usb & (sub == `SUB_2);
      CLK_POL_NEG <= pol_neg_d;
      RX_ON_FALL <= rx_fall_d;
      TX_ON_FALL <= tx_fall_d;
      MASTER_MODE <= (is_spi | is_gpsi) & rcfg_q[`RCFG_MSTPOL];
      // inverted sense: a low bit enables detection
      SYNC_DETECT_EN <= is_usb & ~rcfg_q[`RCFG_SYNCDIS];
      MSB_FIRST <= ract_q[1];
      // busy only stalls a gpsi slave, never 10bt
      TX_HOLD <= is_gpsi & ~rcfg_q[`RCFG_MSTPOL] & ract_q[0] &
                 busy_s2_q;
    end
  end
  // word hand-over from the link side, taken on toggle change
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RX_WORD <= 16'h0000;
      RX_WORD_BITS <= `CNT_ZERO;
      RX_WORD_VALID <= 1'b0;
      acnt_q <= `CNT_ZERO;
    end else begin
      RX_WORD_VALID <= tog_s2_q ^ tog_s3_q;
      if (tog_s2_q ^ tog_s3_q) begin
        RX_WORD <= word_l_q; // held stable by the link side
        RX_WORD_BITS <= wbits_l_q;
        acnt_q <= wbits_l_q;
      end
    end
  end
  // link side: config levels enter via two flops each; software
  // changes them only while the receiver is idle
  logic rst_l1_q, rst_l2_q;
  logic [8:0] cfg_l1_q, cfg_l2_q;
  logic on_l, inv_l, fall_l, msb_l;
  bitcnt_t tgt_l;
  always_ff @(posedge LINK_CLK) begin
    rst_l1_q <= RST_N;
    rst_l2_q <= rst_l1_q;
    cfg_l1_q <= {unit_on, rcfg_q[`RCFG_INV], rx_fall_d, ract_q[1],
                 rcfg_q[`RCFG_CNT]};
    cfg_l2_q <= cfg_l1_q;
  end
  assign on_l = cfg_l2_q[8];
  assign inv_l = cfg_l2_q[7];
  assign fall_l = cfg_l2_q[6];
  assign msb_l = cfg_l2_q[5];
  // zero or counts above a word collect a full word
  assign tgt_l = (cfg_l2_q[4:0] == `CNT_ZERO ||
                  cfg_l2_q[4:0] > `CNT_FULL) ?
                 `CNT_FULL : cfg_l2_q[4:0];
  // falling edge capture for falling edge sampling modes
  logic fall_smp_q;
  always_ff @(negedge LINK_CLK) begin
    fall_smp_q <= RX_DATA;
  end
  // receiver shifter on the serial clock
  bitcnt_t cnt_nx, last_bits;
  assign cnt_nx = cnt_q + `CNT_ONE;
  // final partial word rounds down to whole bytes
  always_comb begin
    if (cnt_q < `CNT_EIGHT) begin
      last_bits = `CNT_ZERO;
    end else if (cnt_q < `CNT_FULL) begin
      last_bits = `CNT_EIGHT;
    end else if (tgt_l == `CNT_FULL) begin
      last_bits = `CNT_FULL;
    end else begin
      last_bits = cnt_q;
    end
  end
  always_ff @(posedge LINK_CLK) begin
    if (!rst_l2_q || !on_l) begin
      st_q <= RX_IDLE;
      bit_q <= 1'b0;
      frame_q <= 1'b0;
      sh_q <= 16'h0000;
      cnt_q <= `CNT_ZERO;
    end else begin
      frame_q <= RX_FRAME;
      bit_q <= (fall_l ? fall_smp_q : RX_DATA) ^ inv_l;
      unique case (st_q)
        RX_IDLE: begin
          sh_q <= 16'h0000;
          cnt_q <= `CNT_ZERO;
          if (frame_q) begin
            st_q <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (!frame_q) begin
            st_q <= RX_IDLE; // frame ended
          end else if (cnt_nx == tgt_l) begin
            cnt_q <= `CNT_ZERO; // word complete
            sh_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_nx;
            if (msb_l) begin
              sh_q <= {sh_q[14:0], bit_q};
            end else begin
              sh_q[cnt_q[3:0]] <= bit_q;
            end
          end
        end
      endcase
    end
  end
  // publish completed or final words across with a toggle
  always_ff @(posedge LINK_CLK) begin
    if (!rst_l2_q) begin
      tog_l_q <= 1'b0;
      word_l_q <= 16'h0000;
      wbits_l_q <= `CNT_ZERO;
    end else if (on_l && st_q == RX_SHIFT) begin
      if (frame_q && cnt_nx == tgt_l) begin
        tog_l_q <= ~tog_l_q;
        word_l_q <= msb_l ? {sh_q[14:0], bit_q} :
                    (sh_q | (16'h0001 << cnt_q[3:0])) &
                    ({16{bit_q}} | ~(16'h0001 << cnt_q[3:0]));
        wbits_l_q <= tgt_l;
      end else if (!frame_q && cnt_q != `CNT_ZERO) begin
        tog_l_q <= ~tog_l_q;
        word_l_q <= sh_q;
        wbits_l_q <= last_bits;
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
endmodule : serdes_rx_cfg
`default_nettype wire

// ==== verilog/serdes_rx_defines.svh ====
// constants for the serdes mode and receive configuration block
`ifndef SERDES_RX_DEFINES_SVH
`define SERDES_RX_DEFINES_SVH
// register byte offsets
`define OFS_MODE 8'h00
`define OFS_RCFG 8'h04
`define OFS_RACT 8'h08
// reset values
`define RST_MODE 7'h00
`define RST_RCFG 8'h00
`define RST_RACT 2'h0
// mode register fields
`define MODE_REV 7
`define MODE_PROTO 6:4
`define MODE_SUB 3:2
`define MODE_CLK 1:0
// receive config fields
`define RCFG_MSTPOL 7
`define RCFG_SYNCDIS 6
`define RCFG_INV 5
`define RCFG_CNT 4:0
// receive activity fields
`define RACT_MSB 7
`define RACT_BUSYEN 6
`define RACT_CRS 5
`define RACT_ACNT 4:0
// protocol codes
`define PRO_OFF 3'h0
`define PRO_10BT 3'h1
`define PRO_USB 3'h2
`define PRO_UART 3'h3
`define PRO_SPI 3'h5
`define PRO_GPSI 3'h6
// submode codes
`define SUB_0 2'h0
`define SUB_1 2'h1
`define SUB_2 2'h2
`define SUB_3 2'h3
// clock source codes
`define CLK_STOP 2'h0
`define CLK_PIN 2'h1
`define CLK_OSC 2'h2
`define CLK_PLL 2'h3
// receive counts
`define CNT_ZERO 5'h00
`define CNT_ONE 5'h01
`define CNT_EIGHT 5'h08
`define CNT_FULL 5'h10
`define WORD_W 16
`endif

// ==== verilog/serdes_rx_pkg.sv ====
// types shared by the serdes mode and receive configuration block
`default_nettype none
package serdes_rx_pkg;
  typedef logic [2:0] proto_t; // protocol code
  typedef logic [1:0] clksrc_t; // serial clock source code
  typedef logic [4:0] bitcnt_t; // receive bit count
  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_e;
endpackage : serdes_rx_pkg
`default_nettype wire

// ==== test/serdes_rx_cfg_props.sv ====
// concurrent checks on the serdes receive configuration block ports
`default_nettype none
module serdes_rx_cfg_props (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire serdes_rx_pkg::proto_t PROTOCOL,
  input wire logic [1:0] SERIAL_CLK_SEL,
  input wire logic USB_LOW_SPEED,
  input wire logic USB_HIGH_SPEED,
  input wire logic RX_ON_FALL,
  input wire logic TX_ON_FALL,
  input wire logic MASTER_MODE,
  input wire logic SYNC_DETECT_EN,
  input wire logic TX_HOLD
);
  import serdes_rx_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // request not yet answered
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  // one cycle of ack, then down
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_pulse: assert property (s_req |=> s_ans)
    else $error("ack is not a one cycle answer");
  a_proto_legal: assert property (
    PROTOCOL inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6})
    else $error("reserved protocol code driven");
  a_usb_speed: assert property (
    USB_LOW_SPEED || USB_HIGH_SPEED |->
    PROTOCOL == 3'h2 && !(USB_LOW_SPEED && USB_HIGH_SPEED))
    else $error("usb speed outside usb mode");
  // every spi submode samples and shifts on opposite edges
  a_spi_edges: assert property (
    PROTOCOL == 3'h5 |-> RX_ON_FALL != TX_ON_FALL)
    else $error("spi edges not opposite");
  a_master_mode: assert property (
    MASTER_MODE |-> PROTOCOL inside {3'h5, 3'h6})
    else $error("master outside spi or gpsi");
  a_sync_usb: assert property (
    SYNC_DETECT_EN |-> PROTOCOL == 3'h2)
    else $error("sync detect outside usb");
  a_hold_gpsi: assert property (
    TX_HOLD |-> PROTOCOL == 3'h6 && !MASTER_MODE)
    else $error("busy hold outside gpsi slave");
  // clock source only moves two cycles after a bus answer
  a_clk_by_write: assert property (
    $changed(SERIAL_CLK_SEL) |-> $past(WB_ACK_O, 2))
    else $error("clock source moved without a write");
endmodule : serdes_rx_cfg_props
bind serdes_rx_cfg serdes_rx_cfg_props u_serdes_rx_cfg_props (
  .CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_ACK_O(WB_ACK_O), .PROTOCOL(PROTOCOL),
  .SERIAL_CLK_SEL(SERIAL_CLK_SEL), .USB_LOW_SPEED(USB_LOW_SPEED),
  .USB_HIGH_SPEED(USB_HIGH_SPEED), .RX_ON_FALL(RX_ON_FALL),
  .TX_ON_FALL(TX_ON_FALL), .MASTER_MODE(MASTER_MODE),
  .SYNC_DETECT_EN(SYNC_DETECT_EN), .TX_HOLD(TX_HOLD));
`default_nettype wire

// ==== test/serdes_rx_peer.sv ====
// behavioural serial peer that sends frames on the link
`default_nettype none
module serdes_rx_peer (
  input wire logic LINK_CLK,
  output logic RX_DATA,
  output logic RX_FRAME
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    RX_DATA = 1'b0;
    RX_FRAME = 1'b0;
  end
  // bits move on the falling edge so the rising sampler sees them settled
  task automatic send(input logic [15:0] w, input int n, input logic m);
    int i;
    repeat (4) @(negedge LINK_CLK);
    // frame leads the first bit by one clock, as the receiver expects
    RX_FRAME <= 1'b1;
    @(negedge LINK_CLK);
    for (i = 0; i < n; i++) begin
      RX_DATA <= m ? w[n - 1 - i] : w[i];
      @(negedge LINK_CLK);
    end
    RX_FRAME <= 1'b0;
    // released line shows the inverse, never a stale bit
    RX_DATA <= ~RX_DATA;
  endtask : send
endmodule : serdes_rx_peer
`default_nettype wire

// ==== test/test_serdes_rx_cfg.sv ====
// self-checking bench for the serdes receive configuration block
`default_nettype none
module test_serdes_rx_cfg;
  timeunit 1ns;
  timeprecision 1ps;
  import serdes_rx_pkg::*;
  logic clk = 1'b0, lclk = 1'b0, rst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic car = 1'b0, pol = 1'b0, busy = 1'b0;
  logic [7:0] adr = 8'h00, q;
  logic [31:0] dat = 32'h0, dato;
  logic ack, ulo, uhi, cpn, rfe, tfe, mst, sde, msb, hold, wvld, rxd, rxf;
  logic [1:0] csel;
  proto_t prot;
  logic [15:0] word;
  logic [4:0] wbits;
  int n_mismatch = 0, checks_done = 0;
  always #10 clk = ~clk;
  // link clock with its own phase
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  serdes_rx_cfg #(.REV_VALUE(1'b0)) u_serdes_rx_cfg ( // arbitrary value
    .CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat),
    .WB_DAT_O(dato), .WB_ACK_O(ack), .LINK_CLK(lclk), .RX_DATA(rxd),
    .RX_FRAME(rxf), .RX_CARRIER(car), .LINE_POL_REV(pol),
    .TX_BUSY(busy), .SERIAL_CLK_SEL(csel), .PROTOCOL(prot),
    .USB_LOW_SPEED(ulo), .USB_HIGH_SPEED(uhi), .CLK_POL_NEG(cpn),
    .RX_ON_FALL(rfe), .TX_ON_FALL(tfe), .MASTER_MODE(mst),
    .SYNC_DETECT_EN(sde), .MSB_FIRST(msb), .TX_HOLD(hold),
    .RX_WORD(word), .RX_WORD_BITS(wbits), .RX_WORD_VALID(wvld));
  serdes_rx_peer u_serdes_rx_peer (
    .LINK_CLK(lclk), .RX_DATA(rxd), .RX_FRAME(rxf));
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dato[7:0];
    if (n >= 50) n_mismatch++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    bus(a, 1'b1, d);
    // outputs follow the stored value one edge later
    @(posedge clk);
    if (a == 8'h00 && d[1:0] == 2'h2) repeat (8) @(posedge clk);
  endtask : wr
  task automatic rr(input string s, input logic [7:0] a, e);
    bus(a, 1'b0, 8'h00);
    chk(s, e, q);
  endtask : rr
  task t_reset;
    rr("mode", 8'h00, 8'h00);
    rr("ract", 8'h08, 8'h00);
    wr(8'h00, 8'h80);
    rr("rev", 8'h00, 8'h00);
    wr(8'h08, 8'hff);
    rr("ract ro", 8'h08, 8'hc0);
    wr(8'h0c, 8'hff);
    rr("hole", 8'h0c, 8'h00);
  endtask : t_reset
  task automatic t_modes;
    int i;
    logic [2:0] p;
    logic [1:0] s;
    logic ok;
    for (i = 0; i < 32; i++) begin
      p = i[4:2];
      ok = p inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
      wr(8'h00, {1'b0, p, 2'h0, i[1:0]});
      chk("proto", ok ? p : 3'h0, prot);
      if (ok) chk("clksrc", i[1:0], csel);
    end
    for (i = 0; i < 4; i++) begin
      s = i[1:0];
      wr(8'h00, {4'h5, s, 2'h1});
      chk("spi", {s[1], ^s, ~^s}, {cpn, rfe, tfe});
      wr(8'h00, {4'h6, s, 2'h1});
      chk("gpsi", {1'b0, s[0], ~s[1]}, {cpn, rfe, tfe});
      wr(8'h00, {4'h2, s, 2'h1});
      chk("usb", {s == 2'h1, s == 2'h2}, {ulo, uhi});
    end
  endtask : t_modes
  task t_cfg;
    wr(8'h00, 8'h51);
    wr(8'h04, 8'h80);
    chk("master", 1'b1, mst);
    wr(8'h00, 8'h21);
    chk("sync", 1'b1, sde);
    wr(8'h04, 8'h40);
    chk("sync", 1'b0, sde);
    pol <= 1'b1;
    wr(8'h00, 8'h11);
    rr("linepol", 8'h04, 8'hc0);
    wr(8'h00, 8'h61);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'hc0);
    busy <= 1'b1;
    repeat (6) @(posedge clk);
    chk("hold", 1'b1, hold);
    wr(8'h08, 8'h80);
    chk("hold", 1'b0, hold);
    chk("msb", 1'b1, msb);
    car <= 1'b1;
    repeat (6) @(posedge clk);
    rr("carrier", 8'h08, 8'ha0);
    car <= 1'b0;
    repeat (6) @(posedge clk);
    rr("carrier", 8'h08, 8'h80);
  endtask : t_cfg
  // one frame from the peer, waiting on the word strobe meanwhile
  task automatic rxw(input logic [15:0] w, input int n, input logic m, ev,
    input logic [15:0] ew, input logic [4:0] eb);
    int k;
    logic got;
    logic [15:0] mk;
    got = 1'b0;
    mk = (eb == 5'h10) ? 16'hffff : (16'h1 << eb) - 16'h1;
    fork
      u_serdes_rx_peer.send(w, n, m);
      for (k = 0; k < 400 && !got; k++) begin
        @(posedge clk);
        got = (wvld === 1'b1);
      end
    join
    @(posedge clk);
    chk("valid", ev, got);
    if (ev) chk("word", ew & mk, word & mk);
    if (ev) chk("bits", eb, wbits);
  endtask : rxw
  task t_rx;
    wr(8'h00, 8'h32);
    wr(8'h04, 8'h08);
    wr(8'h08, 8'h00);
    rxw(16'h00a5, 8, 1'b0, 1'b1, 16'h00a5, 5'h08);
    wr(8'h04, 8'h28);
    rxw(16'h003c, 8, 1'b0, 1'b1, 16'h00c3, 5'h08);
    wr(8'h04, 8'h08);
    wr(8'h08, 8'h80);
    rxw(16'h0096, 8, 1'b1, 1'b1, 16'h0096, 5'h08);
    wr(8'h08, 8'h00);
    wr(8'h04, 8'h10);
    rxw(16'hbeef, 16, 1'b0, 1'b1, 16'hbeef, 5'h10);
    rxw(16'h05a3, 11, 1'b0, 1'b1, 16'h05a3, 5'h08);
    rr("acnt", 8'h08, 8'h08);
    rxw(16'h0013, 5, 1'b0, 1'b1, 16'h0013, 5'h00);
    wr(8'h00, 8'h02);
    rxw(16'h00ff, 8, 1'b0, 1'b0, 16'h0, 5'h00);
    wr(8'h00, 8'h30);
    rxw(16'h00ff, 8, 1'b0, 1'b0, 16'h0, 5'h00);
  endtask : t_rx
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_modes;
    t_cfg;
    t_rx;
    summarize;
  end
  // watchdog well beyond the expected run
  initial begin
    #1000000;
    n_mismatch++;
    summarize;
  end
endmodule : test_serdes_rx_cfg
`default_nettype wire
